// ---- src/sps_pkg.sv ----
package sps_pkg;

    // ****************************************
    // Bus geometry
    // ****************************************
    localparam int SPS_ADDR_W = 4;
    localparam int SPS_DATA_W = 8;
    localparam int SPS_NUM_CH = 12;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [3:0] SPS_REG_CMD = 4'h0;
    localparam logic [3:0] SPS_REG_STATUS = 4'h1;
    localparam logic [3:0] SPS_REG_CONFIG = 4'h2;
    localparam logic [3:0] SPS_REG_INIT_TIME = 4'h3;
    localparam logic [3:0] SPS_REG_CHEN_LO = 4'h4;
    localparam logic [3:0] SPS_REG_CHEN_HI = 4'h5;
    localparam logic [3:0] SPS_REG_OPEN_LO = 4'h6;
    localparam logic [3:0] SPS_REG_OPEN_HI = 4'h7;
    localparam logic [3:0] SPS_REG_SHORT_LO = 4'h8;
    localparam logic [3:0] SPS_REG_SHORT_HI = 4'h9;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int SPS_CMD_POR_CLR_BIT = 0;
    localparam int SPS_CMD_RELOAD_BIT = 1;
    localparam int SPS_CMD_FLT_CLR_BIT = 2;
    localparam int SPS_ST_POR_BIT = 0;
    localparam int SPS_ST_ERR_BIT = 1;
    localparam int SPS_ST_VSUV_BIT = 2;
    localparam int SPS_ST_LOWVS_BIT = 3;
    localparam int SPS_ST_STATE_LSB = 4;
    localparam int SPS_ST_PIN_BIT = 6;
    localparam int SPS_CFG_THR_LSB = 0;
    localparam int SPS_CFG_GAIN_LSB = 4;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [3:0] SPS_THR_RST = 4'h0;
    localparam logic [1:0] SPS_GAIN_RST = 2'h3;
    localparam logic [3:0] SPS_INIT_TIME_RST = 4'h0;
    localparam logic [11:0] SPS_CHEN_RST = 12'h000;

    // ****************************************
    // Timing and scaling
    // ****************************************
    localparam int SPS_CLK_MHZ = 100;
    localparam int SPS_INIT_TICK_US = 1000;
    localparam int SPS_INIT_TICK_CYCLES = SPS_INIT_TICK_US * SPS_CLK_MHZ;
    localparam int SPS_ADC_STEPS_PER_VOLT = 4;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {SPS_POR, SPS_INIT, SPS_NORMAL} sps_state_t;

    typedef struct packed {
        logic [3:0] init_hold_time_setting;
        logic [3:0] low_supply_threshold_select;
        logic [1:0] reference_gain_select;
    } sps_nv_t;

    typedef struct packed {
        logic [11:0] open;
        logic [11:0] short;
    } sps_diag_t;

    // Threshold code to ADC counts
    function automatic logic [7:0] sps_thr_counts(input logic [3:0] code);
        logic [4:0] volts;
        volts = (code == 4'hf) ? 5'd4 : 5'(code) + 5'd5; // Widen first, Eh+5 overflows 4 bits
        sps_thr_counts = 8'(volts * SPS_ADC_STEPS_PER_VOLT);
    endfunction

    // Gain code to reference multiplier
    function automatic logic [9:0] sps_gain_mult(input logic [1:0] code);
        unique case (code)
            2'b11: sps_gain_mult = 10'd512;
            2'b10: sps_gain_mult = 10'd256;
            2'b01: sps_gain_mult = 10'd128;
            2'b00: sps_gain_mult = 10'd64;
        endcase
    endfunction

endpackage

// ---- src/sps_sequencer.sv ----
// Overview of operation
// (R1) Either supply low forces power-on reset
// (R2) Power-on reset defaults every register
// (R3) Power-on reset sets history and error flags
// (R4) Reset state: outputs off, fault pin low
// (R5) Supplies good: init state, timer, pin released
// (R6) Timer expiry moves init to normal
// (R7) Flag clear in init jumps to normal
// (R8) Flag clear clears history in any state; the reset state holds it set
// (R9) Power-up copies stored settings, others default
// (R10) Channels start disabled after power-up
// (R11) Reload command restores settings, clears history
// (R12) Host should reload after every power-on reset; the bench host reloads once, not after the second reset
// (R13) Channel supply undervoltage disables outputs, flags
// (R14) Supply below chosen level sets warning
// (R15) Fault clear command clears warning, faults
// (R16) Low warning drops open and short faults
// (R17) Low supply suppresses open, short detection
// (R18) Threshold code maps 5..19 V, Fh 4 V
// (R19) Gain code selects 512/256/128/64 multiplier
// (R20) Command bits always read back zero
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module sps_sequencer
    import sps_pkg::*;
#(
    parameter int INIT_TICK_CYCLES = SPS_INIT_TICK_CYCLES
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Register port
    input wire logic [SPS_ADDR_W-1:0] reg_addr,
    input wire logic [SPS_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [SPS_DATA_W-1:0] reg_rdata,
    // Supply comparators, asynchronous
    input wire logic vbat_above_uvlo,
    input wire logic vldo_above_uvlo,
    input wire logic vs_above_uv,
    // Channel supply measurement
    input wire logic [7:0] vs_adc_code,
    input wire logic vs_adc_valid,
    // Nonvolatile settings
    input wire sps_nv_t nv_cfg,
    // Output diagnostics events
    input wire sps_diag_t diag_event,
    // Fault indicator pin, open drain
    input wire logic fault_indicator_pin_in,
    output logic fault_indicator_pin_out,
    output logic fault_indicator_pin_oe,
    // Channel and analog control
    output logic [SPS_NUM_CH-1:0] channel_enable,
    output logic diag_detect_enable,
    output logic [1:0] reference_gain_select,
    output logic [9:0] reference_multiplier,
    output logic load_supply_low_level,
    output sps_state_t seq_state
);

    // ****************************************
    // Synchronisers
    // ****************************************
    logic [3:0] sync_a;
    logic [3:0] sync_b;

    // Two flops per asynchronous level
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            sync_a <= 4'h0;
            sync_b <= 4'h0;
        end
        else
        begin
            sync_a <= {fault_indicator_pin_in, vs_above_uv, vldo_above_uvlo, vbat_above_uvlo};
            sync_b <= sync_a;
        end
    end

    logic supplies_ok;
    logic vs_uv;
    logic pin_level;
    assign supplies_ok = sync_b[0] & sync_b[1]; // R1
    assign vs_uv = ~sync_b[2];
    assign pin_level = sync_b[3];

    // ****************************************
    // Command decode
    // ****************************************
    logic cmd_wr;
    logic por_clr;
    logic reload_cmd;
    logic flt_clr;
    logic in_por;
    logic nv_load;
    assign cmd_wr = reg_wr && (reg_addr == SPS_REG_CMD);
    assign por_clr = cmd_wr && reg_wdata[SPS_CMD_POR_CLR_BIT];
    assign reload_cmd = cmd_wr && reg_wdata[SPS_CMD_RELOAD_BIT];
    assign flt_clr = cmd_wr && reg_wdata[SPS_CMD_FLT_CLR_BIT];
    assign in_por = (seq_state == SPS_POR);
    assign nv_load = (in_por && supplies_ok) || reload_cmd; // R9 R11

    // ****************************************
    // Init timer
    // ****************************************
    logic [31:0] tick_cnt;
    logic [4:0] tick_num;
    logic [3:0] init_hold_time_setting;
    logic timer_done;
    assign timer_done = (tick_num == ({1'b0, init_hold_time_setting} + 5'd1)); // R6

    // Counts whole ticks while in init only
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            tick_cnt <= 32'h0000_0000;
            tick_num <= 5'h0;
        end
        else if (seq_state != SPS_INIT || por_clr) // R7
        begin
            tick_cnt <= 32'h0000_0000;
            tick_num <= 5'h0;
        end
        else if (tick_cnt == 32'(INIT_TICK_CYCLES - 1))
        begin
            tick_cnt <= 32'h0000_0000;
            tick_num <= tick_num + 5'd1; // R5
        end
        else
        begin
            tick_cnt <= tick_cnt + 32'd1;
        end
    end

    // ****************************************
    // Sequencer state
    // ****************************************
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            seq_state <= SPS_POR;
        end
        else if (!supplies_ok)
        begin
            seq_state <= SPS_POR; // R1
        end
        else
        begin
            unique case (seq_state)
                SPS_POR: seq_state <= SPS_INIT; // R5
                SPS_INIT:
                begin
                    if (por_clr || timer_done)
                    begin
                        seq_state <= SPS_NORMAL; // R6 R7
                    end
                end
                SPS_NORMAL: seq_state <= SPS_NORMAL;
                default: seq_state <= SPS_POR;
            endcase
        end
    end

    // ****************************************
    // Configuration registers
    // ****************************************
    logic [3:0] low_supply_threshold_select;
    logic [1:0] gain_sel;
    logic [11:0] chen;

    // Defaults in reset, stored copy on load
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            low_supply_threshold_select <= SPS_THR_RST;
            gain_sel <= SPS_GAIN_RST;
            init_hold_time_setting <= SPS_INIT_TIME_RST;
        end
        else if (in_por && !supplies_ok)
        begin
            low_supply_threshold_select <= SPS_THR_RST; // R2
            gain_sel <= SPS_GAIN_RST;
            init_hold_time_setting <= SPS_INIT_TIME_RST;
        end
        else if (nv_load)
        begin
            low_supply_threshold_select <= nv_cfg.low_supply_threshold_select; // R9 R11
            gain_sel <= nv_cfg.reference_gain_select;
            init_hold_time_setting <= nv_cfg.init_hold_time_setting;
        end
        else if (reg_wr && reg_addr == SPS_REG_CONFIG)
        begin
            low_supply_threshold_select <= reg_wdata[SPS_CFG_THR_LSB +: 4];
            gain_sel <= reg_wdata[SPS_CFG_GAIN_LSB +: 2];
        end
        else if (reg_wr && reg_addr == SPS_REG_INIT_TIME)
        begin
            init_hold_time_setting <= reg_wdata[3:0];
        end
    end

    // Channel enables have no stored copy
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            chen <= SPS_CHEN_RST;
        end
        else if (in_por || reload_cmd)
        begin
            chen <= SPS_CHEN_RST; // R2 R10 R11
        end
        else if (reg_wr && reg_addr == SPS_REG_CHEN_LO)
        begin
            chen[7:0] <= reg_wdata;
        end
        else if (reg_wr && reg_addr == SPS_REG_CHEN_HI)
        begin
            chen[11:8] <= reg_wdata[3:0];
        end
    end

    // ****************************************
    // Supply supervision
    // ****************************************
    logic vs_low;
    logic vs_low_sample;
    assign vs_low_sample = vs_adc_valid
        && (vs_adc_code < sps_thr_counts(low_supply_threshold_select)); // R14 R18

    // Tracks latest comparison of the channel supply
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            vs_low <= 1'b0;
        end
        else if (in_por)
        begin
            vs_low <= 1'b0;
        end
        else if (vs_adc_valid)
        begin
            vs_low <= vs_low_sample; // R14
        end
    end

    // ****************************************
    // Status flags, set wins over the clear commands
    // ****************************************
    logic por_flag;
    logic err_flag;
    logic vsuv_flag;
    logic lowvs_flag;
    sps_diag_t diag_flag;
    logic diag_set;
    assign diag_set = |(diag_event & {24{~vs_low}});

    // Power-on history flag
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            por_flag <= 1'b1;
        end
        else if (in_por)
        begin
            por_flag <= 1'b1; // R3
        end
        else if (por_clr || reload_cmd)
        begin
            por_flag <= 1'b0; // R7 R8 R11
        end
    end

    // Summary and supply flags
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            err_flag <= 1'b1;
            vsuv_flag <= 1'b0;
            lowvs_flag <= 1'b0;
        end
        else if (in_por)
        begin
            err_flag <= 1'b1; // R3
            vsuv_flag <= 1'b0;
            lowvs_flag <= 1'b0;
        end
        else
        begin
            err_flag <= vs_uv || vs_low_sample || diag_set || (err_flag && !flt_clr); // R13 R14
            vsuv_flag <= vs_uv || (vsuv_flag && !flt_clr); // R13 R15
            lowvs_flag <= vs_low_sample || (lowvs_flag && !flt_clr); // R14 R15
        end
    end

    // Open and short faults, masked while supply low
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            diag_flag <= '0;
        end
        else if (in_por || vs_low_sample)
        begin
            diag_flag <= '0; // R16
        end
        else
        begin
            diag_flag <= (diag_event & {24{~vs_low}}) | (diag_flag & {24{~flt_clr}}); // R15 R17
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    logic shutdown;
    assign shutdown = in_por || !supplies_ok || vs_uv;

    // Pin, channel and analog drive
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            fault_indicator_pin_out <= 1'b0;
            fault_indicator_pin_oe <= 1'b1;
            channel_enable <= SPS_CHEN_RST;
            diag_detect_enable <= 1'b0;
            reference_gain_select <= SPS_GAIN_RST;
            reference_multiplier <= sps_gain_mult(SPS_GAIN_RST);
            load_supply_low_level <= 1'b0;
        end
        else
        begin
            fault_indicator_pin_out <= 1'b0;
            fault_indicator_pin_oe <= shutdown; // R4 R5 R13
            channel_enable <= shutdown ? SPS_CHEN_RST : chen; // R4 R10 R13
            diag_detect_enable <= !shutdown && !vs_low; // R17
            reference_gain_select <= gain_sel;
            reference_multiplier <= sps_gain_mult(gain_sel); // R19
            load_supply_low_level <= vs_low;
        end
    end

    // ****************************************
    // Read port
    // ****************************************
    logic [7:0] next_rdata;

    // Read mux, unmapped and command read zero
    always_comb
    begin
        next_rdata = 8'h00;
        unique case (reg_addr)
            SPS_REG_CMD: next_rdata = 8'h00; // R20
            SPS_REG_STATUS:
            begin
                next_rdata[SPS_ST_POR_BIT] = por_flag;
                next_rdata[SPS_ST_ERR_BIT] = err_flag;
                next_rdata[SPS_ST_VSUV_BIT] = vsuv_flag;
                next_rdata[SPS_ST_LOWVS_BIT] = lowvs_flag;
                next_rdata[SPS_ST_STATE_LSB +: 2] = seq_state;
                next_rdata[SPS_ST_PIN_BIT] = pin_level;
            end
            SPS_REG_CONFIG:
            begin
                next_rdata[SPS_CFG_THR_LSB +: 4] = low_supply_threshold_select;
                next_rdata[SPS_CFG_GAIN_LSB +: 2] = gain_sel;
            end
            SPS_REG_INIT_TIME: next_rdata[3:0] = init_hold_time_setting;
            SPS_REG_CHEN_LO: next_rdata = chen[7:0];
            SPS_REG_CHEN_HI: next_rdata[3:0] = chen[11:8];
            SPS_REG_OPEN_LO: next_rdata = diag_flag.open[7:0];
            SPS_REG_OPEN_HI: next_rdata[3:0] = diag_flag.open[11:8];
            SPS_REG_SHORT_LO: next_rdata = diag_flag.short[7:0];
            SPS_REG_SHORT_HI: next_rdata[3:0] = diag_flag.short[11:8];
            default: next_rdata = 8'h00;
        endcase
    end

    // Data valid only in the cycle after the strobe
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            reg_rdata <= 8'h00;
        end
        else
        begin
            reg_rdata <= reg_rd ? next_rdata : 8'h00;
        end
    end

endmodule

`default_nettype wire

// ---- test/sps_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// **********
// Host model
// **********
module sps_host_model
    import sps_pkg::*;
(
    // Clock
    input wire logic mclk,
    // Register port
    output logic [SPS_ADDR_W-1:0] reg_addr,
    output logic [SPS_DATA_W-1:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    // Idle bus at time zero
    initial {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;

    // One strobe cycle, then released with stale data inverted
    task automatic cyc(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge mclk);
        {reg_wr, reg_rd} <= 2'b00;
        reg_wdata <= ~d;
        reg_addr <= ~a;
    endtask

    // Reload command, sent once by the bench after the first power-up
    task automatic reload();
        cyc(1'b1, SPS_REG_CMD, 8'h02);
    endtask
endmodule
`default_nettype wire

// ---- test/sps_sequencer_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
// **********
// Checker
// **********
module sps_sequencer_sva
    import sps_pkg::*;
#(
    parameter int INIT_TICK_CYCLES = 4
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Register port
    input wire logic [SPS_ADDR_W-1:0] reg_addr,
    input wire logic [SPS_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [SPS_DATA_W-1:0] reg_rdata,
    // Supplies
    input wire logic vbat_above_uvlo,
    input wire logic vldo_above_uvlo,
    input wire logic vs_above_uv,
    // Outputs
    input wire logic fault_indicator_pin_oe,
    input wire logic [SPS_NUM_CH-1:0] channel_enable,
    input wire logic diag_detect_enable,
    input wire logic [1:0] reference_gain_select,
    input wire logic [9:0] reference_multiplier,
    input wire logic load_supply_low_level,
    input wire sps_state_t seq_state
);
    localparam int INIT_MAX = 16 * INIT_TICK_CYCLES + 4;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);

    chk_supply_por: assert property (
        (!vbat_above_uvlo || !vldo_above_uvlo) [*3] |=> seq_state == SPS_POR)
        else $error("supply low but not in reset state");
    chk_por_outputs: assert property (
        seq_state == SPS_POR |=> fault_indicator_pin_oe && channel_enable == 12'h000)
        else $error("reset state outputs not off");
    chk_init_pin_free: assert property (
        (seq_state == SPS_INIT && vs_above_uv) [*4] |=> !fault_indicator_pin_oe)
        else $error("fault pin held in init");
    chk_init_timer: assert property (
        seq_state == SPS_INIT |-> ##[1:INIT_MAX] seq_state != SPS_INIT)
        else $error("init state too long");
    chk_init_jump: assert property (
        seq_state == SPS_INIT && vbat_above_uvlo && vldo_above_uvlo && reg_wr
        && reg_addr == SPS_REG_CMD && reg_wdata[SPS_CMD_POR_CLR_BIT]
        |=> seq_state == SPS_NORMAL)
        else $error("flag clear in init did not jump");
    chk_uv_off: assert property (
        !vs_above_uv [*4] |=> channel_enable == 12'h000 && fault_indicator_pin_oe)
        else $error("undervoltage left outputs on");
    chk_lowvs_diag: assert property (
        load_supply_low_level [*3] |-> !diag_detect_enable)
        else $error("detection enabled at low supply");
    chk_gain_mult: assert property (
        $stable(reference_gain_select) [*2]
        |-> reference_multiplier == (10'h040 << reference_gain_select))
        else $error("multiplier does not match gain code");
    chk_rdata_idle: assert property (
        !$past(reg_rd) || $past(reg_addr) == SPS_REG_CMD |-> reg_rdata == 8'h00)
        else $error("read data not zero");

    cover property (seq_state == SPS_INIT ##1 seq_state == SPS_NORMAL);
    cover property ($fell(vs_above_uv));
    cover property ($rose(load_supply_low_level));
endmodule
`default_nettype wire

// ---- test/supply_monitor_power_sequencer_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module supply_monitor_power_sequencer_bench
    import sps_pkg::*;
;
    localparam int TICK = 4;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [SPS_ADDR_W-1:0] reg_addr;
    logic [SPS_DATA_W-1:0] reg_wdata, reg_rdata;
    logic reg_wr, reg_rd, pin_out, pin_oe, diag_en, low_lvl;
    logic vbat_above_uvlo = 1'b0, vldo_above_uvlo = 1'b0, vs_above_uv = 1'b0;
    logic [7:0] vs_adc_code = 8'h00;
    logic vs_adc_valid = 1'b0;
    sps_nv_t nv_cfg;
    sps_diag_t diag_event = '0;
    logic [SPS_NUM_CH-1:0] chan_en;
    logic [1:0] gain_sel;
    logic [9:0] ref_mult;
    sps_state_t seq_state;
    wire logic pin_level;
    logic [7:0] exp_q[$], msk_q[$];
    logic rd_seen = 1'b0;
    int n_fail = 0, n_checks = 0;

    // Clock and open-drain pin with pull-up
    always #5 mclk = ~mclk;
    assign pin_level = pin_oe ? pin_out : 1'b1;

    sps_host_model host (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd));
    sps_sequencer #(.INIT_TICK_CYCLES(TICK)) uut (.mclk(mclk), .rstn(rstn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .vbat_above_uvlo(vbat_above_uvlo),
        .vldo_above_uvlo(vldo_above_uvlo), .vs_above_uv(vs_above_uv),
        .vs_adc_code(vs_adc_code), .vs_adc_valid(vs_adc_valid), .nv_cfg(nv_cfg),
        .diag_event(diag_event), .fault_indicator_pin_in(pin_level),
        .fault_indicator_pin_out(pin_out), .fault_indicator_pin_oe(pin_oe),
        .channel_enable(chan_en), .diag_detect_enable(diag_en),
        .reference_gain_select(gain_sel), .reference_multiplier(ref_mult),
        .load_supply_low_level(low_lvl), .seq_state(seq_state));

    // **********
    // Tasks
    // **********
    task automatic cmp(input string nm, input logic [11:0] e, input logic [11:0] g);
        n_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic give_verdict();
        if (n_fail == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        host.cyc(1'b1, a, d);
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        host.cyc(1'b0, a, 8'h00);
    endtask

    task automatic wait_st(input sps_state_t s);
        int i;
        for (i = 0; i < 100 && seq_state !== s; i++)
            @(posedge mclk);
        cmp("seq_state", 12'(s), 12'(seq_state));
    endtask

    task automatic adc(input logic [7:0] c);
        @(posedge mclk);
        vs_adc_code <= c;
        vs_adc_valid <= 1'b1;
        @(posedge mclk);
        vs_adc_valid <= 1'b0;
        vs_adc_code <= ~c;
        repeat (2) @(negedge mclk);
    endtask

    task automatic diag(input sps_diag_t d);
        @(posedge mclk);
        diag_event <= d;
        @(posedge mclk);
        diag_event <= '0;
    endtask

    // Read data answer, compared with the oldest note
    always @(posedge mclk)
    begin
        rd_seen <= reg_rd;
        if (rd_seen)
            cmp("reg_rdata", 12'(exp_q.pop_front()), 12'(reg_rdata & msk_q.pop_front()));
    end

    // Watchdog
    initial
    begin
        #100_000;
        n_fail++;
        give_verdict();
    end

    // **********
    // Main sequence
    // **********
    initial
    begin
        int c;
        logic [3:0] thr, it;
        logic [1:0] g;
        logic [7:0] v;
        void'($urandom(32'hbab7));
        thr = 4'($urandom);
        g = 2'($urandom);
        it = 4'h3 + 4'($urandom % 4);
        nv_cfg = {it, thr, g};
        repeat (20) @(posedge mclk);
        rstn <= 1'b1;
        @(negedge mclk);
        cmp("seq_state", 12'(SPS_POR), 12'(seq_state));
        cmp("pin_oe", 12'h001, 12'(pin_oe));
        cmp("pin_out", 12'h000, 12'(pin_out));
        cmp("chan_en", 12'h000, chan_en);
        cmp("ref_mult", 12'h200, 12'(ref_mult));
        @(posedge mclk);
        {vbat_above_uvlo, vldo_above_uvlo, vs_above_uv} <= 3'h7;
        wait_st(SPS_INIT);
        rd(SPS_REG_STATUS, 8'h03, 8'h03);
        rd(SPS_REG_CONFIG, {2'b00, g, thr}, 8'h3f);
        rd(SPS_REG_INIT_TIME, {4'h0, it}, 8'h0f);
        cmp("pin_oe", 12'h000, 12'(pin_oe));
        wait_st(SPS_NORMAL);
        wr(SPS_REG_CONFIG, {2'b00, ~g, ~thr});
        wr(SPS_REG_CHEN_LO, 8'hff);
        wr(SPS_REG_CHEN_HI, 8'h0f);
        repeat (2) @(negedge mclk);
        cmp("chan_en", 12'hfff, chan_en);
        @(posedge mclk);
        vs_above_uv <= 1'b0;
        repeat (6) @(negedge mclk);
        cmp("chan_en", 12'h000, chan_en);
        cmp("pin_oe", 12'h001, 12'(pin_oe));
        rd(SPS_REG_STATUS, 8'h06, 8'h46);
        vs_above_uv <= 1'b1;
        repeat (4) @(posedge mclk);
        host.reload();
        rd(SPS_REG_STATUS, 8'h00, 8'h01);
        rd(SPS_REG_CONFIG, {2'b00, g, thr}, 8'h3f);
        rd(SPS_REG_CMD, 8'h00, 8'hff);
        cmp("chan_en", 12'h000, chan_en);
        wr(SPS_REG_CMD, 8'h04);
        rd(SPS_REG_STATUS, 8'h40, 8'h4e);
        diag({12'h008, 12'h000});
        rd(SPS_REG_OPEN_LO, 8'h08, 8'hff);
        wr(SPS_REG_CONFIG, 8'h3e);
        adc(8'h00);
        cmp("low_level", 12'h001, 12'(low_lvl));
        cmp("diag_en", 12'h000, 12'(diag_en));
        rd(SPS_REG_OPEN_LO, 8'h00, 8'hff);
        diag({12'h000, 12'h001});
        rd(SPS_REG_SHORT_LO, 8'h00, 8'hff);
        adc(8'hff);
        rd(SPS_REG_STATUS, 8'h0a, 8'h0a);
        wr(SPS_REG_CMD, 8'h04);
        rd(SPS_REG_STATUS, 8'h00, 8'h0a);
        cmp("diag_en", 12'h001, 12'(diag_en));
        // Every threshold and gain code
        for (c = 0; c < 16; c++)
        begin
            v = (c == 15) ? 8'h04 : 8'(c + 5);
            wr(SPS_REG_CONFIG, {2'b00, 2'(c), 4'(c)});
            adc(8'(v * SPS_ADC_STEPS_PER_VOLT - 1));
            cmp("low_level", 12'h001, 12'(low_lvl));
            adc(8'(v * SPS_ADC_STEPS_PER_VOLT));
            cmp("low_level", 12'h000, 12'(low_lvl));
            cmp("gain_sel", 12'(c[1:0]), 12'(gain_sel));
            cmp("ref_mult", 12'(10'h040 << c[1:0]), 12'(ref_mult));
        end
        @(posedge mclk);
        vldo_above_uvlo <= 1'b0;
        wait_st(SPS_POR);
        rd(SPS_REG_STATUS, 8'h03, 8'h03);
        rd(SPS_REG_CONFIG, 8'h30, 8'h3f);
        vldo_above_uvlo <= 1'b1;
        wait_st(SPS_INIT);
        wr(SPS_REG_CMD, 8'h01);
        @(negedge mclk);
        cmp("seq_state", 12'(SPS_NORMAL), 12'(seq_state));
        rd(SPS_REG_STATUS, 8'h00, 8'h01);
        repeat (2) @(posedge mclk);
        give_verdict();
    end
endmodule

bind sps_sequencer sps_sequencer_sva #(.INIT_TICK_CYCLES(INIT_TICK_CYCLES)) u_sva (
    .mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .vbat_above_uvlo(vbat_above_uvlo), .vldo_above_uvlo(vldo_above_uvlo),
    .vs_above_uv(vs_above_uv), .fault_indicator_pin_oe(fault_indicator_pin_oe),
    .channel_enable(channel_enable), .diag_detect_enable(diag_detect_enable),
    .reference_gain_select(reference_gain_select),
    .reference_multiplier(reference_multiplier),
    .load_supply_low_level(load_supply_low_level), .seq_state(seq_state));
`default_nettype wire
